// ===== verilog/mcu_core_pkg.sv
// Shared constants and carrier types for the option latch and instruction sequencer.
// Assumes one oscillator clock; the program memory and datapath sit on the same clock.
package mcu_core_pkg;
    // Configuration word layout
    localparam int OSC_TYPE_BIT = 12;
    localparam int WDT_DIS_BIT  = 11;
    localparam int CYCLE_BIT    = 10;
    localparam int PROTECT_BIT  = 9;
    localparam int XFREQ_BIT    = 8;
    localparam int RCSRC_BIT    = 7;
    localparam int DRIVE_BIT    = 6;
    localparam logic [12:0] CFG_USED_MASK = 13'h1FC0;
    localparam logic [12:0] CFG_RESET     = 13'h1FC0;   // Erased-state option image
    localparam logic [12:0] UID_RESET     = 13'h1FFF;   // Arbitrary value
    // Instruction word fields
    localparam int TOP_BIT    = 12;
    localparam int SUB_BIT    = 11;
    localparam int BOP_MSB    = 10;
    localparam int BOP_LSB    = 9;
    localparam int OPN_MSB    = 11;
    localparam int OPN_LSB    = 8;
    localparam int MISC_MSB   = 10;
    localparam int MISC_LSB   = 6;
    localparam int SKIP_BIT   = 7;
    localparam int DEST_BIT   = 6;
    localparam int REG_MSB    = 5;
    localparam int REG_LSB    = 0;
    localparam int BIT_MSB    = 8;
    localparam int BIT_LSB    = 6;
    localparam int K8_MSB     = 7;
    localparam int K10_MSB    = 9;
    localparam logic [1:0]  BOP_CLR  = 2'h0;
    localparam logic [1:0]  BOP_SET  = 2'h1;
    localparam logic [1:0]  BOP_TST0 = 2'h2;
    localparam logic [3:0]  OPN_DJZ  = 4'h5;
    localparam logic [3:0]  OPN_JZ   = 4'h7;
    localparam logic [3:0]  OPN_RETL = 4'hC;
    localparam logic [4:0]  MISC_SEL = 5'h00;
    localparam logic [12:0] OP_SLEEP = 13'h0003;
    localparam logic [12:0] OP_WDTC  = 13'h0004;
    localparam logic [12:0] OP_RET   = 13'h0012;
    localparam logic [12:0] OP_RETI  = 13'h0013;
    localparam logic [12:0] OP_INT   = 13'h1E01;
    localparam logic [5:0]  PC_REG_ADDR = 6'h02;
    // Oscillator periods per instruction cycle, as last phase index
    localparam logic [1:0]  PH_LAST_TWO  = 2'h1;
    localparam logic [1:0]  PH_LAST_FOUR = 2'h3;
    // Wishbone register map (byte addresses)
    localparam logic [7:0]  ADR_CTRL   = 8'h00;
    localparam logic [7:0]  ADR_STATUS = 8'h04;
    localparam logic [7:0]  ADR_CONFIG = 8'h08;
    localparam logic [7:0]  ADR_USERID = 8'h0C;
    localparam int CTRL_PROG_BIT = 0;
    localparam int CTRL_WAKE_BIT = 1;
    localparam int ST_WDT_BIT    = 7;
    localparam int ST_SLEEP_BIT  = 8;
    localparam int ST_HALT_BIT   = 9;
    localparam int ST_LOAD_BIT   = 10;

    typedef enum logic [2:0] {
        CL_MISC, CL_BYTE, CL_BITCLR, CL_BITSET, CL_BITTST0, CL_BITTST1, CL_JUMP, CL_LIT
    } instr_class_t;

    typedef struct packed {
        logic osc_xtal;
        logic wdt_disable_n;
        logic cycle_four;
        logic code_protect_n;
        logic xtal_high;
        logic rc_external;
        logic drive_high;
    } opt_t;

    typedef struct packed {
        instr_class_t cls;
        logic [5:0]   reg_addr;
        logic [2:0]   bit_num;
        logic [9:0]   literal;
        logic         writes_reg;
        logic         skip_op;
        logic         pc_flow;
    } dec_t;
endpackage

// ===== verilog/cycle_div.sv
// Oscillator-period divider: counts 2 or 4 periods and flags the last one.
// Assumes clr and four come from logic on the same clock.
module cycle_div (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic clr,
    input  wire logic four,
    output logic      last
);
    typedef struct packed {
        logic [1:0] phase;
    } div_state_t;

    div_state_t st;
    div_state_t next_st;

    // Last phase depends on the selected cycle length
    assign last = (st.phase == (four ? mcu_core_pkg::PH_LAST_FOUR : mcu_core_pkg::PH_LAST_TWO));

    // Restart on clear so an instruction cycle always begins at phase zero
    always_comb begin
        next_st = st;
        if (clr || last) begin
            next_st.phase = 2'h0;
        end else begin
            next_st.phase = 2'(st.phase + 2'h1);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule

// ===== verilog/code_option_and_instr_timing.sv
// Option latch, instruction decoder and instruction-cycle sequencer of the core.
// Assumes the program memory offers words with valid/ready on mclk, and the datapath
// returns the skip test result on skip_true during the first cycle of a skip instruction.
//
// Summary of operation
// - Option bit 12 picks oscillator family: 0 RC, 1 crystal.
// - Option bit 11 low enables the watchdog, high disables it.
// - Option bit 10 sets instruction cycle: two or four oscillator periods.
// - Option bit 9 low turns program memory read protection on.
// - Option bit 8 picks crystal range, only effective in crystal mode.
// - Option bit 7 picks internal-capacitor or fully external RC network.
// - Option bit 6 picks low or high oscillator drive power.
// - Low six option bits carry no function and are ignored.
// - Option and ID words sit outside program memory, unreachable while running.
// - A separate 13-bit user ID word holds a user code.
// - Every instruction is one 13-bit word: opcode plus operand fields.
// - One cycle per instruction; register writes to the PC take two.
// - Jumps, calls, returns and successful skips take two cycles.
// - Timer clock is oscillator divided by four in four-period mode, else two.
// - Any bit of any register can be set, cleared or tested.
// - Port registers serve as operands like general registers.
// - Register field gives the address of the register used.
// - Bit field gives the bit number within the selected register.
// - Literals are 8-bit, or 10-bit in jump and call.
// - Sleep opcode clears watchdog, stops oscillator, updates timeout and power-down flags.
module code_option_and_instr_timing (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic                clk_en,
    input  wire logic                wb_cyc,
    input  wire logic                wb_stb,
    input  wire logic                wb_we,
    input  wire logic [7:0]          wb_adr,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack,
    input  wire logic [12:0]         instr_word,
    input  wire logic                instr_valid,
    output logic                     instr_ready,
    input  wire logic                skip_true,
    input  wire logic                wake_req,
    output logic                     dec_valid,
    output mcu_core_pkg::dec_t       dec,
    output logic                     extra_cycle,
    output logic                     wdt_enable,
    output logic                     wdt_clear,
    output logic                     osc_stop,
    output logic                     flags_wr,
    output logic                     flag_timeout,
    output logic                     flag_powerdown,
    output logic                     timer_tick,
    output mcu_core_pkg::opt_t       osc_opts,
    output logic                     xtal_high_eff,
    output logic                     read_protect
);
    typedef enum logic [2:0] {
        ST_LOAD, ST_FETCH, ST_EXEC, ST_EXTRA, ST_SLEEP, ST_HALT
    } fsm_t;

    typedef struct packed {
        fsm_t                fsm;
        mcu_core_pkg::opt_t  opt;
        logic                loaded;
        logic                prog_mode;
        logic [12:0]         cfg;
        logic [12:0]         uid;
        mcu_core_pkg::dec_t  dec;
        logic                dec_valid;
        logic                two_fixed;
        logic                is_sleep;
        logic                ready;
        logic                extra;
        logic                wdt_en;
        logic                wdt_clear;
        logic                flags_wr;
        logic                flag_to;
        logic                flag_pd;
        logic                osc_stop;
        logic                tick;
        logic                xtal_eff;
        logic                protect;
        logic                ack;
        logic [31:0]         rdata;
    } state_t;

    state_t st;
    state_t next_st;
    logic   exec_last;
    logic   tmr_last;
    logic   accept;
    logic   wb_req;
    logic   wb_rd_ok;

    // Split the 13-bit word into class and operand fields
    function automatic mcu_core_pkg::dec_t decode(input logic [12:0] w);
        mcu_core_pkg::dec_t d;
        d = '0;
        d.reg_addr = w[mcu_core_pkg::REG_MSB:mcu_core_pkg::REG_LSB];
        d.bit_num  = w[mcu_core_pkg::BIT_MSB:mcu_core_pkg::BIT_LSB];
        if (w[mcu_core_pkg::TOP_BIT]) begin
            if (!w[mcu_core_pkg::SUB_BIT]) begin
                d.cls     = mcu_core_pkg::CL_JUMP;
                d.literal = w[mcu_core_pkg::K10_MSB:0];
                d.pc_flow = 1'b1;
            end else begin
                d.cls     = mcu_core_pkg::CL_LIT;
                d.literal = {2'h0, w[mcu_core_pkg::K8_MSB:0]};
                d.pc_flow = (w[mcu_core_pkg::OPN_MSB:mcu_core_pkg::OPN_LSB] == mcu_core_pkg::OPN_RETL)
                            || (w == mcu_core_pkg::OP_INT);
            end
        end else if (w[mcu_core_pkg::SUB_BIT]) begin
            // Single-bit set, clear and test on any register
            case (w[mcu_core_pkg::BOP_MSB:mcu_core_pkg::BOP_LSB])
                mcu_core_pkg::BOP_CLR: begin
                    d.cls        = mcu_core_pkg::CL_BITCLR;
                    d.writes_reg = 1'b1;
                end
                mcu_core_pkg::BOP_SET: begin
                    d.cls        = mcu_core_pkg::CL_BITSET;
                    d.writes_reg = 1'b1;
                end
                mcu_core_pkg::BOP_TST0: begin
                    d.cls     = mcu_core_pkg::CL_BITTST0;
                    d.skip_op = 1'b1;
                end
                default: begin
                    d.cls     = mcu_core_pkg::CL_BITTST1;
                    d.skip_op = 1'b1;
                end
            endcase
        end else if (w[mcu_core_pkg::MISC_MSB:mcu_core_pkg::MISC_LSB] == mcu_core_pkg::MISC_SEL) begin
            d.cls     = mcu_core_pkg::CL_MISC;
            d.pc_flow = (w == mcu_core_pkg::OP_RET) || (w == mcu_core_pkg::OP_RETI);
        end else begin
            // Byte ops: destination bit says whether the register is written
            d.cls        = mcu_core_pkg::CL_BYTE;
            d.writes_reg = w[mcu_core_pkg::DEST_BIT];
            d.skip_op    = w[mcu_core_pkg::SKIP_BIT]
                           && ((w[mcu_core_pkg::OPN_MSB:mcu_core_pkg::OPN_LSB] == mcu_core_pkg::OPN_DJZ)
                           || (w[mcu_core_pkg::OPN_MSB:mcu_core_pkg::OPN_LSB] == mcu_core_pkg::OPN_JZ));
        end
        return d;
    endfunction

    // Two cycles whenever the program counter changes, independent of skip outcome
    function automatic logic fixed_two(input mcu_core_pkg::dec_t d);
        return d.pc_flow || (d.writes_reg && (d.reg_addr == mcu_core_pkg::PC_REG_ADDR));
    endfunction

    // Byte-lane merge for the 13-bit option and ID words
    function automatic logic [12:0] merge13(input logic [12:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
        logic [12:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[12:8] = wd[12:8];
        end
        return r;
    endfunction

    // Unpack the used option bits; the low six bits never reach any logic
    function automatic mcu_core_pkg::opt_t unpack_opt(input logic [12:0] c);
        mcu_core_pkg::opt_t o;
        o.osc_xtal       = c[mcu_core_pkg::OSC_TYPE_BIT];
        o.wdt_disable_n  = c[mcu_core_pkg::WDT_DIS_BIT];
        o.cycle_four     = c[mcu_core_pkg::CYCLE_BIT];
        o.code_protect_n = c[mcu_core_pkg::PROTECT_BIT];
        o.xtal_high      = c[mcu_core_pkg::XFREQ_BIT];
        o.rc_external    = c[mcu_core_pkg::RCSRC_BIT];
        o.drive_high     = c[mcu_core_pkg::DRIVE_BIT];
        return o;
    endfunction

    // Instruction-cycle phase counter, restarted on every accepted word
    cycle_div u_exec_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (clk_en),
        .clr     (accept),
        .four    (st.opt.cycle_four),
        .last    (exec_last)
    );

    // Free-running timer prescaler, frozen while the oscillator is stopped
    cycle_div u_tmr_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ce      (clk_en && !st.osc_stop),
        .clr     (1'b0),
        .four    (st.opt.cycle_four),
        .last    (tmr_last)
    );

    assign accept   = (st.fsm == ST_FETCH) && st.ready && instr_valid && !st.prog_mode;
    assign wb_req   = wb_cyc && wb_stb && !st.ack;
    // Option and ID words are reachable only once execution has halted
    assign wb_rd_ok = (st.fsm == ST_HALT);

    always_comb begin
        next_st           = st;
        next_st.dec_valid = 1'b0;
        next_st.wdt_clear = 1'b0;
        next_st.flags_wr  = 1'b0;
        next_st.ack       = wb_req;
        next_st.tick      = tmr_last && !st.osc_stop;

        // Sequencer
        case (st.fsm)
            ST_LOAD: begin
                // Options captured once after reset, then held until the next reset
                next_st.opt      = unpack_opt(st.cfg);
                next_st.wdt_en   = !st.cfg[mcu_core_pkg::WDT_DIS_BIT];
                next_st.xtal_eff = st.cfg[mcu_core_pkg::OSC_TYPE_BIT]
                                   && st.cfg[mcu_core_pkg::XFREQ_BIT];
                next_st.protect  = !st.cfg[mcu_core_pkg::PROTECT_BIT];
                next_st.loaded   = 1'b1;
                next_st.fsm      = st.prog_mode ? ST_HALT : ST_FETCH;
            end
            ST_FETCH: begin
                if (st.prog_mode) begin
                    next_st.fsm = ST_HALT;
                end else if (accept) begin
                    next_st.dec       = decode(instr_word);
                    next_st.dec_valid = 1'b1;
                    next_st.two_fixed = fixed_two(decode(instr_word));
                    next_st.is_sleep  = (instr_word == mcu_core_pkg::OP_SLEEP);
                    next_st.fsm       = ST_EXEC;
                    if (instr_word == mcu_core_pkg::OP_SLEEP) begin
                        next_st.wdt_clear = 1'b1;
                        next_st.flags_wr  = 1'b1;
                        next_st.flag_to   = 1'b1;
                        next_st.flag_pd   = 1'b0;
                    end else if (instr_word == mcu_core_pkg::OP_WDTC) begin
                        next_st.wdt_clear = 1'b1;
                        next_st.flags_wr  = 1'b1;
                        next_st.flag_to   = 1'b1;
                        next_st.flag_pd   = 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                if (exec_last) begin
                    if (st.two_fixed || (st.dec.skip_op && skip_true)) begin
                        next_st.fsm   = ST_EXTRA;
                        next_st.extra = 1'b1;
                    end else if (st.is_sleep) begin
                        next_st.fsm      = ST_SLEEP;
                        next_st.osc_stop = 1'b1;
                    end else begin
                        next_st.fsm = ST_FETCH;
                    end
                end
            end
            ST_EXTRA: begin
                if (exec_last) begin
                    next_st.fsm   = ST_FETCH;
                    next_st.extra = 1'b0;
                end
            end
            ST_SLEEP: begin
                // Wake by request or by software through the control register
                if (wake_req || (wb_req && wb_we && (wb_adr == mcu_core_pkg::ADR_CTRL)
                    && wb_sel[0] && wb_dat_i[mcu_core_pkg::CTRL_WAKE_BIT])) begin
                    next_st.fsm      = ST_FETCH;
                    next_st.osc_stop = 1'b0;
                end
            end
            ST_HALT: begin
                if (!st.prog_mode) begin
                    next_st.fsm = ST_FETCH;
                end
            end
            default: begin
                next_st.fsm = ST_LOAD;
            end
        endcase

        // Wishbone slave: one access per request, answered in the next cycle
        if (wb_req && wb_we) begin
            case (wb_adr)
                mcu_core_pkg::ADR_CTRL: begin
                    if (wb_sel[0]) begin
                        next_st.prog_mode = wb_dat_i[mcu_core_pkg::CTRL_PROG_BIT];
                    end
                end
                mcu_core_pkg::ADR_CONFIG: begin
                    if (wb_rd_ok) begin
                        next_st.cfg = merge13(st.cfg, wb_dat_i, wb_sel) & mcu_core_pkg::CFG_USED_MASK;
                    end
                end
                mcu_core_pkg::ADR_USERID: begin
                    if (wb_rd_ok) begin
                        next_st.uid = merge13(st.uid, wb_dat_i, wb_sel);
                    end
                end
                default: begin
                end
            endcase
        end
        next_st.rdata = 32'h0000_0000;
        if (wb_req && !wb_we) begin
            case (wb_adr)
                mcu_core_pkg::ADR_CTRL: begin
                    next_st.rdata[mcu_core_pkg::CTRL_PROG_BIT] = st.prog_mode;
                end
                mcu_core_pkg::ADR_STATUS: begin
                    next_st.rdata[6:0]                        = st.opt;
                    next_st.rdata[mcu_core_pkg::ST_WDT_BIT]   = st.wdt_en;
                    next_st.rdata[mcu_core_pkg::ST_SLEEP_BIT] = (st.fsm == ST_SLEEP);
                    next_st.rdata[mcu_core_pkg::ST_HALT_BIT]  = (st.fsm == ST_HALT);
                    next_st.rdata[mcu_core_pkg::ST_LOAD_BIT]  = st.loaded;
                end
                mcu_core_pkg::ADR_CONFIG: begin
                    next_st.rdata[12:0] = wb_rd_ok ? st.cfg : 13'h0000;
                end
                mcu_core_pkg::ADR_USERID: begin
                    next_st.rdata[12:0] = wb_rd_ok ? st.uid : 13'h0000;
                end
                default: begin
                end
            endcase
        end
        next_st.ready = (next_st.fsm == ST_FETCH) && !next_st.prog_mode;
    end

    // Option image and ID survive only as long as this register file; reset restores defaults
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st     <= '0;
            st.fsm <= ST_LOAD;
            st.cfg <= mcu_core_pkg::CFG_RESET;
            st.uid <= mcu_core_pkg::UID_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Every output is a field of the registered state
    assign wb_dat_o       = st.rdata;
    assign wb_ack         = st.ack;
    assign instr_ready    = st.ready;
    assign dec_valid      = st.dec_valid;
    assign dec            = st.dec;
    assign extra_cycle    = st.extra;
    assign wdt_enable     = st.wdt_en;
    assign wdt_clear      = st.wdt_clear;
    assign osc_stop       = st.osc_stop;
    assign flags_wr       = st.flags_wr;
    assign flag_timeout   = st.flag_to;
    assign flag_powerdown = st.flag_pd;
    assign timer_tick     = st.tick;
    assign osc_opts       = st.opt;
    assign xtal_high_eff  = st.xtal_eff;
    assign read_protect   = st.protect;
endmodule

// ===== bench/core_monitor.sv
// Concurrent checks on the option outputs and the instruction sequencer.
// Assumes clk_en high while latency relations are judged; bound from tb.
module core_monitor (
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    input  wire logic               instr_ready,
    input  wire logic               instr_valid,
    input  wire logic               dec_valid,
    input  wire mcu_core_pkg::dec_t dec,
    input  wire logic               extra_cycle,
    input  wire logic               wdt_enable,
    input  wire logic               wdt_clear,
    input  wire logic               flags_wr,
    input  wire logic               timer_tick,
    input  wire mcu_core_pkg::opt_t osc_opts,
    input  wire logic               xtal_high_eff,
    input  wire logic               read_protect
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] age;
    logic       pc_write;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Options are judged only once the load after reset has surely landed
    always_ff @(posedge mclk) begin
        if (sys_rst)
            age <= 2'h0;
        else if (age != 2'h3)
            age <= age + 2'h1;
    end
    // Flow changes and writes to the program counter cost a second cycle
    assign pc_write = dec.pc_flow || (dec.writes_reg && dec.reg_addr == mcu_core_pkg::PC_REG_ADDR);
    a_wdt_from_opt: assert property (age == 2'h3 |-> wdt_enable == !osc_opts.wdt_disable_n)
        else $error("watchdog enable disagrees with option");
    a_protect_from_opt: assert property (age == 2'h3 |-> read_protect == !osc_opts.code_protect_n)
        else $error("read protect disagrees with option");
    a_xtal_range_eff: assert property (age == 2'h3 |-> xtal_high_eff == (osc_opts.osc_xtal && osc_opts.xtal_high))
        else $error("crystal range active outside crystal mode");
    a_opts_held: assert property (age == 2'h3 |-> $stable(osc_opts))
        else $error("options changed while running");
    a_decode_next: assert property (instr_ready && instr_valid && clk_en |=> dec_valid && !instr_ready)
        else $error("accepted word not decoded next cycle");
    a_two_cycle: assert property (dec_valid && pc_write && clk_en |-> ##[1:4] extra_cycle)
        else $error("flow change without second cycle");
    a_one_cycle: assert property (dec_valid && !pc_write && !dec.skip_op |=> !extra_cycle [*5])
        else $error("plain instruction took a second cycle");
    a_sleep_flags: assert property (wdt_clear |-> flags_wr && dec_valid)
        else $error("watchdog clear without flag update");
    a_tick_quarter: assert property (timer_tick && osc_opts.cycle_four |=> !timer_tick [*3])
        else $error("timer tick faster than a quarter");
endmodule

// ===== bench/prog_mem.sv
// Program memory model: offers queued 13-bit words on a valid/ready handshake.
// Assumes the bench pushes words into q; an idle cycle follows every accepted word.
module prog_mem (
    input  wire logic        mclk,
    input  wire logic        instr_ready,
    output logic [12:0]      instr_word,
    output logic             instr_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [12:0] q[$];
    initial begin
        instr_word = 13'h0000;
        instr_valid = 1'b0;
    end
    // Hold each offer until taken; a taken word is not left on the lines
    always @(posedge mclk) begin
        if (instr_valid && instr_ready) begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
        end else if (!instr_valid && q.size() > 0) begin
            instr_valid <= 1'b1;
            instr_word <= q.pop_front(); // Whole word per offer
        end
    end
endmodule

// ===== bench/tb.sv
// Self-checking bench for the option latch and instruction sequencer.
// Assumes the erased option image after reset, so cycles are four periods long.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               mclk = 1'b0, sys_rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic               skip_true = 1'b0, wake_req = 1'b0;
    logic [7:0]         wb_adr = 8'h00;
    logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, wq[$];
    logic               wb_ack, instr_valid, instr_ready, dec_valid, extra_cycle, wdt_enable, wdt_clear;
    logic               osc_stop, flags_wr, flag_timeout, flag_powerdown, timer_tick, xtal_high_eff, read_protect;
    logic [12:0]        instr_word;
    logic [37:0]        dq[$], t;
    logic [1:0]         fq[$];
    logic [31:0]        r;
    mcu_core_pkg::dec_t dec;
    mcu_core_pkg::opt_t osc_opts;
    int                 error_cnt = 0, checks = 0, ticks = 0, seed = 92;
    always #20 mclk = ~mclk;
    code_option_and_instr_timing DUT (.mclk, .sys_rst, .clk_en(1'b1), .wb_cyc, .wb_stb, .wb_we, .wb_adr,
        .wb_dat_i, .wb_sel(4'hF), .wb_dat_o, .wb_ack, .instr_word, .instr_valid, .instr_ready, .skip_true,
        .wake_req, .dec_valid, .dec, .extra_cycle, .wdt_enable, .wdt_clear, .osc_stop, .flags_wr,
        .flag_timeout, .flag_powerdown, .timer_tick, .osc_opts, .xtal_high_eff, .read_protect);
    prog_mem mem (.mclk, .instr_ready, .instr_word, .instr_valid);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out();
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Classic single cycle: hold until ack is sampled, then release
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_i <= d;
        @(posedge mclk);
        while (wb_ack !== 1'b1) @(posedge mclk);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wq.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    // Note masked decode fields, queue the word, wait for its decode
    task automatic op(input logic [12:0] w, input logic [18:0] m, input logic [18:0] e);
        dq.push_back({m, e});
        mem.q.push_back(w);
        while (dq.size() > 0) @(posedge mclk);
    endtask
    // Match every read answer, decode and flag update with the oldest note
    always @(posedge mclk) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0)
            chk("wb_dat_o", wq.pop_front(), wb_dat_o);
        if (dec_valid === 1'b1 && dq.size() > 0) begin
            t = dq.pop_front();
            chk("dec", {13'h0, t[18:0]}, {13'h0, {dec.reg_addr, dec.bit_num, dec.literal} & t[37:19]});
        end
        if (flags_wr === 1'b1 && fq.size() > 0)
            chk("flags", {30'h0, fq.pop_front()}, {30'h0, flag_timeout, flag_powerdown});
    end
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            ticks += int'(timer_tick);
        end
        chk("ticks", 32'h0000000A, ticks);
        rd(mcu_core_pkg::ADR_STATUS, 32'h0000047F);
        rd(mcu_core_pkg::ADR_CONFIG, 32'h00000000);
        rd(8'h10, 32'h00000000);
        xfer(1'b1, mcu_core_pkg::ADR_CTRL, 32'h00000001);
        repeat (4) @(posedge mclk);
        rd(mcu_core_pkg::ADR_CONFIG, 32'h00001FC0);
        xfer(1'b1, mcu_core_pkg::ADR_CONFIG, 32'h0000003F);
        rd(mcu_core_pkg::ADR_CONFIG, 32'h00000000);
        rd(mcu_core_pkg::ADR_USERID, 32'h00001FFF);
        rd(mcu_core_pkg::ADR_STATUS, 32'h0000067F);
        xfer(1'b1, mcu_core_pkg::ADR_CTRL, 32'h00000000);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            skip_true <= r[10];
            op({2'b01, i[1:0], r[8:0]}, 19'h7FC00, {r[5:0], r[8:6], 10'h000});
            op({3'b101, r[9:0]}, 19'h003FF, {9'h000, r[9:0]});
            op({5'b11000, r[7:0]}, 19'h000FF, {11'h000, r[7:0]});
        end
        op(13'h0042, 19'h7E000, {6'h02, 13'h0000});
        fq.push_back(2'h2);
        op(mcu_core_pkg::OP_SLEEP, 19'h00000, 19'h00000);
        while (osc_stop !== 1'b1) @(posedge mclk);
        wake_req <= 1'b1;
        @(posedge mclk);
        wake_req <= 1'b0;
        fq.push_back(2'h3);
        op(mcu_core_pkg::OP_WDTC, 19'h00000, 19'h00000);
        repeat (20) @(posedge mclk);
        close_out();
    end
    // Watchdog for a hung handshake
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        close_out();
    end
endmodule
bind code_option_and_instr_timing core_monitor mon (.mclk, .sys_rst, .clk_en, .instr_ready, .instr_valid,
    .dec_valid, .dec, .extra_cycle, .wdt_enable, .wdt_clear, .flags_wr, .timer_tick, .osc_opts,
    .xtal_high_eff, .read_protect);
